//--- shared/pssu_regs.svh
// register offsets, field positions, reset values and trigger codes
//
// Overview of operation
// - four-valued set activation method setting
// - method 0: load edge, only when allowed
// - method 1: load edge activates set at once
// - method 2: selection change, only when allowed
// - method 3: selection change activates at once
// - command-to-change switch activates current selection
// - set index from bits weighted one, two
// - enter ups mode while trigger true
// - trigger false: leave ups mode
// - digital input may request ups mode
// - network word bit may request ups
// - ups active raises fixed warning code
// - ups active drives status trigger true
// - ups active sets status word bit 15
// - ups active disables phase failure detection
// - ups active selects reduced limits, overload curve
// - inputs high or low active, default high
// - polarity zero low-active, one high-active
`ifndef PSSU_REGS_SVH
`define PSSU_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PSSU_OFS_CTRL     8'h00
`define PSSU_OFS_ASSIGN   8'h04
`define PSSU_OFS_STATUS   8'h08
`define PSSU_OFS_SWORD2   8'h0c
`define PSSU_OFS_WARN     8'h10

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PSSU_CTRL_METHOD_LSB 0
`define PSSU_CTRL_POL_BIT    2
`define PSSU_CTRL_RST        32'h0000_0004
`define PSSU_ASSIGN_RST      32'h0000_0000
`define PSSU_SWORD2_UPS_BIT  15
`define PSSU_UPS_WARN_CODE   16'h3180

// ----------------------------------------------------------------
// trigger codes
// ----------------------------------------------------------------
`define PSSU_TRIG_NONE    8'h00
`define PSSU_TRIG_TRUE    8'h01
`define PSSU_TRIG_DI1     8'h0b
`define PSSU_TRIG_NET0    8'h20
`define PSSU_TRIG_UPS_ACT 8'h76
`define PSSU_NUM_DI       5
`define PSSU_NET_W        16

`endif

//--- shared/pssu_pkg.sv
// types shared by the change-over and ups control block
package pssu_pkg;
  // sampled trigger sources after polarity handling
  typedef struct packed {
    logic [4:0]  din;   // digital inputs, asserted = 1
    logic [15:0] net;   // inbound_net_control_word
  } pssu_src_t;

  // activation method encoding
  typedef enum logic [1:0] {
    PSSU_M_CMD_GATED = 2'h0,
    PSSU_M_CMD_NOW   = 2'h1,
    PSSU_M_CHG_GATED = 2'h2,
    PSSU_M_CHG_NOW   = 2'h3
  } pssu_method_t;
endpackage : pssu_pkg

//--- verilog/pssu_trig_sel.sv
// trigger selector: maps an assignment code to one trigger level
`timescale 1ns/10ps
`include "pssu_regs.svh"
module pssu_trig_sel (
  input  wire logic [7:0]         i_code, // assignment code
  input  wire pssu_pkg::pssu_src_t i_src, // trigger sources
  output logic                    o_trig  // selected trigger level
);
  import pssu_pkg::*;

  logic [`PSSU_NUM_DI-1:0] din_hit;   // matching digital input
  logic [`PSSU_NET_W-1:0]  net_hit;   // matching net word bit

  // ----------------------------------------------------------------
  // per-source code match
  // ----------------------------------------------------------------
  genvar g;
  for (g = 0; g < `PSSU_NET_W; g++) begin : g_src
    if (g < `PSSU_NUM_DI) begin : g_di
      assign din_hit[g] = (i_code == `PSSU_TRIG_DI1 + 8'(g)) &
                          i_src.din[g];
    end
    assign net_hit[g] = (i_code == `PSSU_TRIG_NET0 + 8'(g)) &
                        i_src.net[g];
  end

  // not connected reads false; unknown codes read false too
  assign o_trig = (i_code == `PSSU_TRIG_TRUE) | (|din_hit) | (|net_hit);
endmodule : pssu_trig_sel

//--- verilog/pssu_edge.sv
// change and rising-edge detector against the previous sample
`timescale 1ns/10ps
module pssu_edge #(
  parameter int W = 1              // number of bits watched
) (
  input  wire logic         i_clk,  // control clock
  input  wire logic         i_rstn, // async reset, active low
  input  wire logic [W-1:0] i_cur,  // current sampled value
  output logic      [W-1:0] o_rise, // false-to-true per bit
  output logic              o_chg   // any bit changed
);
  logic [W-1:0] prev_r; // previous-cycle value

  // ----------------------------------------------------------------
  // previous sample store
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_r <= '0;
    end else begin
      prev_r <= i_cur;
    end
  end

  assign o_rise = i_cur & ~prev_r;
  assign o_chg  = |(i_cur ^ prev_r);
endmodule : pssu_edge

//--- verilog/pssu_ctrl.sv
// parameter-set change-over and ups mode control with avalon slave
`timescale 1ns/10ps
`include "pssu_regs.svh"
module pssu_ctrl (
  input  wire logic        i_clk,            // 50 mhz control clock
  input  wire logic        i_rstn,           // async reset, low
  // avalon-mm slave
  input  wire logic [7:0]  i_address,        // byte address
  input  wire logic        i_read,           // read request
  input  wire logic        i_write,          // write request
  input  wire logic [31:0] i_writedata,      // write data
  input  wire logic [3:0]  i_byteenable,     // byte lanes
  output logic      [31:0] o_readdata,       // read data
  output logic             o_waitrequest,    // stall while high
  // drive side
  input  wire logic [4:0]  i_din,            // digital input pins
  input  wire logic [15:0] i_net_word,       // inbound net word
  input  wire logic        i_drive_inhibit,  // drive disabled
  input  wire logic        i_motor_stopped,  // motor at rest
  input  wire logic        i_error_active,   // error present
  output logic [1:0]       o_active_set,     // loaded set index
  output logic             o_set_load,       // pulse: set loaded
  output logic             o_ups_active,     // ups mode state
  output logic             o_ups_status_trig,// routable trigger
  output logic [15:0]      o_status_word2,   // drive status word 2
  output logic             o_warn_valid,     // warning present
  output logic [15:0]      o_warn_code,      // warning error code
  output logic             o_phase_fail_en,  // phase fail detect on
  output logic             o_reduced_limits, // reduced dc limits
  output logic             o_ovl_adapted     // ups overload curve
);
  import pssu_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]  ctrl_r;          // method and polarity
  logic [31:0]  assign_r;        // four trigger assignment codes
  logic         wait_r;          // waitrequest flop
  logic [31:0]  rdata_r;         // read data flop
  logic [31:0]  rdata_nxt;       // decoded read value
  logic         req;             // exactly one of read, write pending
  logic         acc;             // request completes this edge
  pssu_method_t method;          // current activation method
  pssu_method_t method_prev_r;   // method one cycle ago
  logic         pol_high;        // inputs high active
  pssu_src_t    src;             // polarity-corrected sources
  logic [3:0]   trig;            // sel0, sel1, load, ups
  logic [1:0]   sel_now;         // selected set index
  logic         load_rise;       // load trigger false-to-true
  logic         sel_chg;         // selection bits changed
  logic         allowed;         // inhibited, stopped or error
  logic         switch_chg;      // command to change switch
  logic         pend_r;          // method 2 switch waiting
  logic         act;             // activate selected set now
  logic         set_load_r;      // load pulse flop
  logic [1:0]   active_set_r;    // active set flop
  logic         ups_r;           // ups mode flop
  logic         phase_en_r;      // phase failure detect flop
  logic         red_r;           // reduced limit flop
  logic [15:0]  sword2_r;        // status word 2 flop
  logic [15:0]  warn_code_r;     // warning code flop

  // ----------------------------------------------------------------
  // avalon slave: one wait state, reads answer on the second edge
  // ----------------------------------------------------------------
  assign req = i_read ^ i_write;   // both high is illegal, ignored
  assign acc = req & ~wait_r;

  // waitrequest drops for one cycle after a request is seen
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0;
    if (i_address == `PSSU_OFS_CTRL) begin
      rdata_nxt = {29'h0, ctrl_r[2:0]};
    end else if (i_address == `PSSU_OFS_ASSIGN) begin
      rdata_nxt = assign_r;
    end else if (i_address == `PSSU_OFS_STATUS) begin
      // live state: set, ups, pending switch, inputs
      rdata_nxt = {22'h0, pend_r, set_load_r, red_r, phase_en_r,
                   ups_r, active_set_r, sel_now, trig[2]};
    end else if (i_address == `PSSU_OFS_SWORD2) begin
      rdata_nxt = {16'h0, sword2_r};
    end else if (i_address == `PSSU_OFS_WARN) begin
      rdata_nxt = {16'h0, warn_code_r};
    end
  end

  // read data is captured while waitrequest is still high
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= 32'h0;
    end else if (i_read & ~i_write & wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // writes land on the edge where waitrequest is sampled low
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r   <= `PSSU_CTRL_RST;
      assign_r <= `PSSU_ASSIGN_RST;
    end else if (acc & i_write) begin
      if (i_address == `PSSU_OFS_CTRL) begin
        if (i_byteenable[0]) begin
          ctrl_r[7:0] <= {5'h0, i_writedata[2:0]};
        end
      end else if (i_address == `PSSU_OFS_ASSIGN) begin
        for (int b = 0; b < 4; b++) begin
          if (i_byteenable[b]) begin
            assign_r[b*8 +: 8] <= i_writedata[b*8 +: 8];
          end
        end
      end
    end
  end

  assign o_readdata    = rdata_r;
  assign o_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // input polarity and trigger selection
  // ----------------------------------------------------------------
  assign method   = pssu_method_t'(ctrl_r[`PSSU_CTRL_METHOD_LSB +: 2]);
  assign pol_high = ctrl_r[`PSSU_CTRL_POL_BIT];
  // zero means low active, so the terminal level is inverted
  assign src.din  = pol_high ? i_din : ~i_din;
  assign src.net  = i_net_word;

  // one selector per function: sel bit0, sel bit1, load, ups
  genvar f;
  for (f = 0; f < 4; f++) begin : g_fn
    pssu_trig_sel u_sel (
      .i_code (assign_r[f*8 +: 8]),
      .i_src  (src),
      .o_trig (trig[f])
    );
  end

  assign sel_now = {trig[1], trig[0]};

  // ----------------------------------------------------------------
  // edge and change detection
  // ----------------------------------------------------------------
  pssu_edge #(.W(1)) u_load_edge (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_cur  (trig[2]),
    .o_rise (load_rise),
    .o_chg  ()
  );

  pssu_edge #(.W(2)) u_sel_edge (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_cur  (sel_now),
    .o_rise (),
    .o_chg  (sel_chg)
  );

  // ----------------------------------------------------------------
  // activation decision
  // ----------------------------------------------------------------
  assign allowed = i_drive_inhibit | i_motor_stopped | i_error_active;
  // method moved from a command value to a change value
  assign switch_chg = ~method_prev_r[1] & method[1];

  always_comb begin
    case (method)
      PSSU_M_CMD_GATED: act = load_rise & allowed;
      PSSU_M_CMD_NOW:   act = load_rise;
      PSSU_M_CHG_GATED: act = (sel_chg | switch_chg | pend_r)
                              & allowed;
      PSSU_M_CHG_NOW:   act = sel_chg | switch_chg;
      default:          act = 1'b0;
    endcase
  end

  // previous method, for spotting the switch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      method_prev_r <= PSSU_M_CMD_GATED;
    end else begin
      method_prev_r <= method;
    end
  end

  // a switch into method 2 while running waits until allowed;
  // leaving method 2 drops the wait so no stale load happens
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_r <= 1'b0;
    end else if (method != PSSU_M_CHG_GATED || act) begin
      pend_r <= 1'b0;
    end else if (switch_chg) begin
      pend_r <= 1'b1;
    end
  end

  // active set and its load pulse
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      active_set_r <= 2'h0;
      set_load_r   <= 1'b0;
    end else begin
      set_load_r <= act;
      if (act) begin
        active_set_r <= sel_now;
      end
    end
  end

  assign o_active_set = active_set_r;
  assign o_set_load   = set_load_r;

  // ----------------------------------------------------------------
  // ups mode: all effects follow the trigger level, registered one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ups_r       <= 1'b0;
      phase_en_r  <= 1'b1;
      red_r       <= 1'b0;
      sword2_r    <= 16'h0;
      warn_code_r <= 16'h0;
    end else begin
      ups_r      <= trig[3];
      phase_en_r <= ~trig[3];
      red_r      <= trig[3];
      sword2_r   <= 16'(trig[3]) << `PSSU_SWORD2_UPS_BIT;
      warn_code_r <= trig[3] ? `PSSU_UPS_WARN_CODE : 16'h0;
    end
  end

  // no timer on the request: the ten-second mains gap is kept
  // by the outside controller
  assign o_ups_active      = ups_r;
  assign o_ups_status_trig = ups_r;
  assign o_warn_valid      = ups_r;
  assign o_warn_code       = warn_code_r;
  assign o_status_word2    = sword2_r;
  assign o_phase_fail_en   = phase_en_r;
  assign o_reduced_limits  = red_r;
  assign o_ovl_adapted     = red_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_m0_block;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CMD_GATED) && !allowed |=> !set_load_r;
  endproperty
  a_m0_block: assert property (p_m0_block)
    else $error("method 0 loaded a set while running");

  // a permitted load edge must really load, not only stay quiet
  property p_m0_load;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CMD_GATED) && load_rise && allowed |=>
      set_load_r && (active_set_r == $past(sel_now));
  endproperty
  a_m0_load: assert property (p_m0_load)
    else $error("method 0 permitted edge did not load");

  property p_m1_load;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CMD_NOW) && load_rise |=>
      set_load_r && (active_set_r == $past(sel_now));
  endproperty
  a_m1_load: assert property (p_m1_load)
    else $error("method 1 edge did not load selection");

  property p_m2_block;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CHG_GATED) && !allowed |=>
      $stable(active_set_r);
  endproperty
  a_m2_block: assert property (p_m2_block)
    else $error("method 2 changed set while running");

  property p_m2_load;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CHG_GATED) && sel_chg && allowed |=>
      set_load_r && (active_set_r == $past(sel_now));
  endproperty
  a_m2_load: assert property (p_m2_load)
    else $error("method 2 permitted change did not load");

  // a switch held back in method 2 fires once the permit shows up
  property p_pend_load;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CHG_GATED) && pend_r && allowed |=> set_load_r;
  endproperty
  a_pend_load: assert property (p_pend_load)
    else $error("pending switch not loaded when permitted");

  property p_m3_chg;
    @(posedge i_clk) disable iff (!i_rstn)
    (method == PSSU_M_CHG_NOW) && sel_chg |=>
      set_load_r && (active_set_r == $past(sel_now));
  endproperty
  a_m3_chg: assert property (p_m3_chg)
    else $error("method 3 change did not load selection");

  property p_switch;
    @(posedge i_clk) disable iff (!i_rstn)
    (method_prev_r == PSSU_M_CMD_GATED) &&
      (method == PSSU_M_CHG_NOW) |=> set_load_r;
  endproperty
  a_switch: assert property (p_switch)
    else $error("switch to method 3 did not load");

  property p_ups_follow;
    @(posedge i_clk) disable iff (!i_rstn)
    trig[3] ##1 trig[3] |=> o_ups_active && o_ups_status_trig;
  endproperty
  a_ups_follow: assert property (p_ups_follow)
    else $error("ups mode not entered");

  property p_ups_leave;
    @(posedge i_clk) disable iff (!i_rstn)
    !trig[3] |=> !o_ups_active && o_phase_fail_en && !o_warn_valid;
  endproperty
  a_ups_leave: assert property (p_ups_leave)
    else $error("ups mode not left");

  property p_ups_effects;
    @(posedge i_clk) disable iff (!i_rstn)
    o_ups_active |-> (o_warn_code == `PSSU_UPS_WARN_CODE) &&
      o_status_word2[`PSSU_SWORD2_UPS_BIT] && !o_phase_fail_en &&
      o_reduced_limits;
  endproperty
  a_ups_effects: assert property (p_ups_effects)
    else $error("ups effects incomplete");

  property p_bus_ack;
    @(posedge i_clk) disable iff (!i_rstn)
    req && wait_r |=> !o_waitrequest ##1 o_waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("waitrequest did not drop for one cycle");

  // read and write together is refused: the slave keeps stalling
  property p_bus_refuse;
    @(posedge i_clk) disable iff (!i_rstn)
    i_read && i_write |=> o_waitrequest;
  endproperty
  a_bus_refuse: assert property (p_bus_refuse)
    else $error("read and write together were answered");
endmodule : pssu_ctrl

//--- bench/pssu_drive_model.sv
// drive-controller side model: terminals, net word and permit levels
`timescale 1ns/10ps
module pssu_drive_model #(
  parameter int GAP_CYC = 4          // mains-off to ups request, scaled
) (
  input  wire logic        i_clk,     // control clock
  input  wire logic [3:0]  i_sel,     // wanted sel and load levels
  input  wire logic [15:0] i_net,     // wanted net word
  input  wire logic [2:0]  i_permit,  // {error, stopped, inhibit}
  input  wire logic        i_ups_req, // ups wanted, mains already off
  output logic      [4:0]  o_din,     // digital input terminals
  output logic      [15:0] o_net,     // inbound_net_control_word
  output logic      [2:0]  o_permit   // permit levels to the drive
);
  int gap_r; // cycles since mains went off with ups wanted

  // ----------------------------------------------------------------
  // mains gap: the ups terminal closes only after the dc link settles
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_ups_req) begin
      gap_r <= 0;
    end else if (gap_r < GAP_CYC) begin
      gap_r <= gap_r + 1;
    end
  end

  // terminals follow the wanted levels; the ups terminal is held back
  assign o_din    = {i_ups_req && (gap_r == GAP_CYC), i_sel};
  assign o_net    = i_net;
  assign o_permit = i_permit;
endmodule : pssu_drive_model

//--- bench/pssu_ctrl_tb_top.sv
// self-checking bench for the change-over and ups control block
`timescale 1ns/10ps
`include "pssu_regs.svh"
`define PSSU_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  $display("unexpected %s: expected %h seen %h", nm, e, g); \
  n_errors++; end end
module pssu_ctrl_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        i_clk = 1'b0;          // 50 mhz clock
  logic        i_rstn = 1'b0;         // reset, active low
  logic [7:0]  address = 8'h00;       // avalon address
  logic        read = 1'b0;           // avalon read
  logic        write = 1'b0;          // avalon write
  logic [31:0] writedata = 32'h0;     // avalon write data
  logic [31:0] readdata;              // avalon read data
  logic        waitrequest;           // avalon stall
  logic [4:0]  din;                   // terminals from the model
  logic [15:0] net;                   // net word from the model
  logic [2:0]  permit;                // permit levels from the model
  logic [3:0]  sel_v = 4'h0;          // wanted sel and load levels
  logic [15:0] net_v = 16'h0;         // wanted net word
  logic [2:0]  permit_v = 3'h0;       // wanted permit levels
  logic        ups_req = 1'b0;        // ups wanted by the controller
  localparam int GAP = 4;             // scaled mains gap in cycles
  logic [1:0]  act_set;               // loaded set
  logic        set_load;              // load pulse
  logic        ups, ups_trig, warn_v, pf_en, red, ovl; // ups outputs
  logic [15:0] sword2, warn_code;     // status word and warning code
  logic [31:0] q;                     // last read value
  int          n_errors = 0;          // mismatches
  int          checked = 0;           // comparisons

  always #10 i_clk = ~i_clk;

  pssu_drive_model #(.GAP_CYC(GAP)) drv (.i_clk(i_clk), .i_sel(sel_v),
    .i_net(net_v), .i_permit(permit_v), .i_ups_req(ups_req),
    .o_din(din), .o_net(net), .o_permit(permit));

  pssu_ctrl dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_address(address),
    .i_read(read), .i_write(write), .i_writedata(writedata),
    .i_byteenable(4'hf), .o_readdata(readdata),
    .o_waitrequest(waitrequest), .i_din(din), .i_net_word(net),
    .i_drive_inhibit(permit[0]), .i_motor_stopped(permit[1]),
    .i_error_active(permit[2]), .o_active_set(act_set),
    .o_set_load(set_load), .o_ups_active(ups),
    .o_ups_status_trig(ups_trig), .o_status_word2(sword2),
    .o_warn_valid(warn_v), .o_warn_code(warn_code),
    .o_phase_fail_en(pf_en), .o_reduced_limits(red),
    .o_ovl_adapted(ovl));

  // ----------------------------------------------------------------
  // closing report
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // one avalon transfer; held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    address   <= a;
    write     <= w;
    read      <= ~w;
    writedata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (k == 20) begin
      n_errors++;
      summarize();
    end
  endtask : bus

  // no load pulse for n cycles
  task quiet(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
      `PSSU_CHK("set_load idle", 1'b0, set_load)
    end
  endtask : quiet

  // load pulse exactly one edge after the cause
  task pulse(input logic [1:0] s);
    @(posedge i_clk);
    #1;
    `PSSU_CHK("set_load", 1'b1, set_load)
    `PSSU_CHK("active_set", s, act_set)
  endtask : pulse

  // load after a method write, whose latency spans the bus answer
  task wait_load(input logic [1:0] s);
    int k;
    for (k = 0; k < 6; k++) begin
      @(posedge i_clk);
      #1;
      if (set_load === 1'b1) break;
    end
    `PSSU_CHK("switch load", 1'b1, set_load)
    `PSSU_CHK("switch set", s, act_set)
  endtask : wait_load

  // every ups consequence follows the mode level
  task chk_ups(input logic e);
    repeat (2) @(posedge i_clk);
    #1;
    `PSSU_CHK("ups", e, ups)
    `PSSU_CHK("ups trig", e, ups_trig)
    `PSSU_CHK("sword2", {e, 15'h0}, sword2)
    `PSSU_CHK("warn", e, warn_v)
    `PSSU_CHK("warn code", e ? 16'h3180 : 16'h0, warn_code)
    `PSSU_CHK("phase en", ~e, pf_en)
    `PSSU_CHK("reduced", e, red)
    `PSSU_CHK("overload", e, ovl)
  endtask : chk_ups

  // drive-side levels, changed just after an edge
  task put_sel(input logic [3:0] v);
    @(posedge i_clk);
    sel_v <= v;
  endtask : put_sel

  task put_net(input logic [15:0] v);
    @(posedge i_clk);
    net_v <= v;
  endtask : put_net

  task put_permit(input logic [2:0] v);
    @(posedge i_clk);
    permit_v <= v;
  endtask : put_permit

  // a raised request shows at the terminal only after the mains gap
  task req_ups(input logic lvl);
    @(posedge i_clk);
    ups_req <= lvl;
    if (lvl) repeat (GAP) @(posedge i_clk);
  endtask : req_ups

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    bus(1'b0, `PSSU_OFS_CTRL, 32'h0);
    `PSSU_CHK("ctrl reset", 32'h4, q)
    bus(1'b0, `PSSU_OFS_ASSIGN, 32'h0);
    `PSSU_CHK("assign reset", 32'h0, q)
    bus(1'b0, 8'h20, 32'h0);
    `PSSU_CHK("unmapped", 32'h0, q)
    // sel0 DI1, sel1 DI2, load DI3, ups DI5
    bus(1'b1, `PSSU_OFS_ASSIGN, 32'h0f0d0c0b);
    // method 0: no load without permit, selection change ignored
    put_sel(4'h3);
    quiet(2);
    put_sel(4'h7);
    quiet(3);
    put_sel(4'h3);
    put_permit(3'h1);
    put_sel(4'h7);
    pulse(2'h3);
    quiet(2);
    // method 1: load edge acts whatever the drive state
    put_permit(3'h0);
    bus(1'b1, `PSSU_OFS_CTRL, 32'h5);
    put_sel(4'h1);
    quiet(2);
    put_sel(4'h5);
    pulse(2'h1);
    // command to change method loads the current selection at once
    put_sel(4'h0);
    quiet(1);
    bus(1'b1, `PSSU_OFS_CTRL, 32'h7);
    wait_load(2'h0);
    put_sel(4'h2);
    pulse(2'h2);
    // method 2: change loads only while permitted
    bus(1'b1, `PSSU_OFS_CTRL, 32'h6);
    quiet(2);
    put_sel(4'h3);
    quiet(2);
    put_permit(3'h4);
    put_sel(4'h1);
    pulse(2'h1);
    put_permit(3'h2);
    put_sel(4'h0);
    pulse(2'h0);
    // switch into method 2 without permit waits for the permit
    put_permit(3'h0);
    bus(1'b1, `PSSU_OFS_CTRL, 32'h5);
    put_sel(4'h2);
    quiet(1);
    bus(1'b1, `PSSU_OFS_CTRL, 32'h6);
    quiet(3);
    put_permit(3'h2);
    wait_load(2'h2);
    put_permit(3'h0);
    // ups from a digital input, then released
    req_ups(1'b1);
    chk_ups(1'b1);
    bus(1'b0, `PSSU_OFS_SWORD2, 32'h0);
    `PSSU_CHK("sword2 reg", 32'h8000, q)
    bus(1'b0, `PSSU_OFS_WARN, 32'h0);
    `PSSU_CHK("warn reg", 32'h3180, q)
    // status: set 2 loaded and selected, ups on, limits reduced
    bus(1'b0, `PSSU_OFS_STATUS, 32'h0);
    `PSSU_CHK("status reg", 32'hb4, q)
    req_ups(1'b0);
    chk_ups(1'b0);
    // low-active inputs: an open terminal asserts
    bus(1'b1, `PSSU_OFS_CTRL, 32'h2);
    chk_ups(1'b1);
    bus(1'b1, `PSSU_OFS_CTRL, 32'h6);
    chk_ups(1'b0);
    // ups from net word bit 5
    bus(1'b1, `PSSU_OFS_ASSIGN, 32'h250d0c0b);
    put_net(16'h0020);
    chk_ups(1'b1);
    put_net(16'h0000);
    chk_ups(1'b0);
    summarize();
  end
endmodule : pssu_ctrl_tb_top
